// *** hw/scm_pkg.sv ***
// Constants, register layouts and types for the system clock mode control
package scm_pkg;

   // ----------------------------------------------------------------
   // Clock rates and timing
   // ----------------------------------------------------------------
   localparam int unsigned REF_CLK_KHZ     = 25000;
   localparam int unsigned FAST_OSC_KHZ    = 20000;
   localparam int unsigned SLOW_OSC_KHZ    = 32;
   localparam int unsigned FAST_SETTLE_US  = 16;
   localparam int unsigned FAST_SETTLE_CYC =
      (FAST_SETTLE_US * REF_CLK_KHZ + 999) / 1000;
   localparam int unsigned SETTLE_W        = 12;
   localparam logic [2:0]  SWITCH_SYS_TICKS = 3'h4;
   localparam int unsigned DIV_TAPS        = 7;
   localparam int unsigned PHASE_W         = 16;

   // ----------------------------------------------------------------
   // Register bus and map
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam logic [3:0]  ADDR_SYS_CLOCK_CTRL = 4'h0;
   localparam logic [3:0]  ADDR_FAST_OSC_CTRL  = 4'h1;
   localparam logic [3:0]  ADDR_INT_STATUS     = 4'h2;
   localparam logic [3:0]  ADDR_INT_ENABLE     = 4'h3;
   localparam logic [3:0]  ADDR_INT_CLEAR      = 4'h4;
   localparam logic [3:0]  ADDR_MODE_STATUS    = 4'h5;

   // ----------------------------------------------------------------
   // Field values and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] SEL_FAST_DIV1 = 3'h0;
   localparam logic [2:0] SEL_SUB       = 3'h7;
   localparam logic [7:0] SCC_RST       = 8'h00;
   localparam logic       FOSC_EN_RST   = 1'b1;
   localparam logic       FOSC_STB_RST  = 1'b0;
   localparam int unsigned INT_W        = 3;
   localparam int unsigned INT_STABLE   = 0;
   localparam int unsigned INT_SWITCH   = 1;
   localparam int unsigned INT_HALT     = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sysclk_select;
      logic [2:0] rsv;
      logic       halt_fast_keep;
      logic       halt_slow_keep;
   } scm_sys_clock_ctrl_s;

   typedef enum logic [5:0] {
      MODE_FAST                  = 6'h01,
      MODE_SLOW                  = 6'h02,
      MODE_SLEEP                 = 6'h04,
      MODE_HALT_SUB_ONLY_MODE    = 6'h08,
      MODE_HALT_BOTH_CLOCKS_MODE = 6'h10,
      MODE_HALT_FAST_ONLY_MODE   = 6'h20
   } scm_mode_e;

   typedef struct packed {
      logic cpu;
      logic sys;
      logic fast;
      logic sub;
      logic slow;
   } scm_clk_en_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } scm_reg_req_s;

endpackage

// *** hw/scm_phase_gen.sv ***
// Fractional tick generator modelling an RC oscillator on the ref clock
`timescale 1ns/1ns
`default_nettype none
module scm_phase_gen
   import scm_pkg::*;
#(
   parameter int unsigned NUM = FAST_OSC_KHZ,
   parameter int unsigned DEN = REF_CLK_KHZ,
   parameter int unsigned W   = PHASE_W
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   output var  logic tick_o
);

   logic [W-1:0] acc_ff;
   logic [W-1:0] nxt_acc;
   logic         nxt_tick;
   logic [W:0]   sum;

   // ----------------------------------------------------------------
   // Accumulator
   // ----------------------------------------------------------------
   always_comb begin
      sum      = {1'b0, acc_ff} + (W+1)'(NUM);
      nxt_acc  = acc_ff;
      nxt_tick = 1'b0;
      if (run_i) begin
         if (sum >= (W+1)'(DEN)) begin
            nxt_acc  = W'(sum - (W+1)'(DEN));
            nxt_tick = 1'b1;
         end else begin
            nxt_acc = sum[W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         acc_ff <= '0;
         tick_o <= 1'b0;
      end else begin
         acc_ff <= nxt_acc;
         tick_o <= nxt_tick;
      end
   end

endmodule
`default_nettype wire

// *** hw/scm_fast_div.sv ***
// Binary prescaler giving fast clock ticks divided by 1 to 2**(TAPS-1)
`timescale 1ns/1ns
`default_nettype none
module scm_fast_div
   import scm_pkg::*;
#(
   parameter int unsigned TAPS = DIV_TAPS
) (
   input  wire logic            ref_clk_i,
   input  wire logic            rst_i,
   input  wire logic            tick_i,
   output logic [TAPS-1:0]      div_tick_o
);

   logic [TAPS-2:0] cnt_ff;
   logic [TAPS-2:0] nxt_cnt;

   // ----------------------------------------------------------------
   // Counter and taps
   // ----------------------------------------------------------------
   always_comb begin
      nxt_cnt = tick_i ? cnt_ff + 1'b1 : cnt_ff;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign div_tick_o[0] = tick_i;
   for (genvar k = 1; k < TAPS; k++) begin : g_tap
      assign div_tick_o[k] = tick_i & (&cnt_ff[k-1:0]);
   end

endmodule
`default_nettype wire

// *** hw/scm_top.sv ***
// System clock select, oscillator control and halt mode sequencing
//
// How it works
// - Select codes 0..6 give fast clock divided 1..64; code 7 gives sub clock.
// - Fast clock comes from an internal 20MHz RC oscillator model.
// - Sub clock comes from an internal 32kHz RC oscillator model.
// - FAST mode: CPU runs from fast clock divided by selected ratio.
// - SLOW mode: CPU runs from sub clock; sub and slow oscillator stay on.
// - In SLOW mode the fast oscillator runs only if its enable bit is set or a fast code (0..6) is selected.
// - Halt with both keep bits low: SLEEP, CPU, sys, fast and sub clocks stop.
// - Slow oscillator clock keeps running in SLEEP for the watchdog.
// - Halt, fast-keep low, slow-keep high: sub only; sys on if code 7.
// - Halt with both keep bits high: sys, fast and sub clocks keep running.
// - Halt, fast-keep high, slow-keep low: fast only; sys on for codes 0..6.
// - Six modes; keep bits only matter when a halt executes.
// - Clock control: select bits 7..5, fast-keep bit 1, slow-keep bit 0.
// - Oscillator control: stable flag bit 1 read-only, enable bit 0.
// - Setting enable clears stable flag, sets it once oscillator settles.
// - After reset enable is 1 and stable flag is 0.
`timescale 1ns/1ns
`default_nettype none
module scm_top
   import scm_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = FAST_SETTLE_CYC
) (
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   input  wire scm_reg_req_s       reg_req_i,
   input  wire logic               halt_i,
   input  wire logic               wake_i,
   output logic [DATA_W-1:0]       rdata_o,
   output scm_clk_en_s             clk_en_o,
   output logic [DIV_TAPS-1:0]     fast_div_en_o,
   output scm_mode_e               mode_o,
   output logic                    switch_busy_o,
   output logic                    irq_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   scm_sys_clock_ctrl_s  scc_ff, nxt_scc;
   logic                 fosc_en_ff, nxt_fosc_en;
   logic                 fosc_stb_ff, nxt_fosc_stb;
   logic [SETTLE_W-1:0]  settle_ff, nxt_settle;
   logic [INT_W-1:0]     int_sts_ff, nxt_int_sts;
   logic [INT_W-1:0]     int_en_ff, nxt_int_en;
   logic [DATA_W-1:0]    nxt_rdata;
   scm_mode_e            nxt_mode;
   logic [2:0]           act_sel_ff, nxt_act_sel;
   logic [2:0]           sw_cnt_ff, nxt_sw_cnt;
   logic                 nxt_busy;
   logic                 nxt_irq;
   scm_clk_en_s          nxt_clk_en;
   logic [DIV_TAPS-1:0]  nxt_fast_div;

   logic                 fast_raw;
   logic                 slow_raw;
   logic [DIV_TAPS-1:0]  div_tick;
   logic                 cpu_on;
   logic                 fast_run;
   logic                 sub_on;
   logic                 sys_on;
   logic                 cur_tick;
   logic                 tgt_tick;
   logic                 tgt_ready;
   logic                 switch_done;
   logic                 halt_evt;
   logic [INT_W-1:0]     events;
   logic                 wr_scc, wr_fosc, wr_ien, wr_iclr;

   // Tick for one select code; same decode serves current and target
   function automatic logic sel_tick(input logic [2:0]          sel,
                                     input logic [DIV_TAPS-1:0] div,
                                     input logic                sub);
      if (sel == SEL_SUB) begin
         sel_tick = sub;
      end else begin
         sel_tick = div[sel];
      end
   endfunction

   // ----------------------------------------------------------------
   // Oscillators and prescaler
   // ----------------------------------------------------------------
   scm_phase_gen #(
      .NUM (FAST_OSC_KHZ),
      .DEN (REF_CLK_KHZ),
      .W   (PHASE_W)
   ) u_fast_rc_osc (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .run_i     (fast_run & fosc_stb_ff),
      .tick_o    (fast_raw)
   );

   // Always running: the watchdog depends on it
   scm_phase_gen #(
      .NUM (SLOW_OSC_KHZ),
      .DEN (REF_CLK_KHZ),
      .W   (PHASE_W)
   ) u_slow_rc_osc (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .run_i     (1'b1),
      .tick_o    (slow_raw)
   );

   scm_fast_div #(
      .TAPS (DIV_TAPS)
   ) u_fast_div (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .tick_i     (fast_raw),
      .div_tick_o (div_tick)
   );

   // ----------------------------------------------------------------
   // Clock gating per mode
   // ----------------------------------------------------------------
   always_comb begin
      cpu_on = (mode_o == MODE_FAST) || (mode_o == MODE_SLOW);
      // Fast osc is forced on while it is or will be the system source
      fast_run = (cpu_on && (fosc_en_ff || act_sel_ff != SEL_SUB
                             || scc_ff.sysclk_select != SEL_SUB))
               || mode_o == MODE_HALT_BOTH_CLOCKS_MODE
               || mode_o == MODE_HALT_FAST_ONLY_MODE;
      sub_on = cpu_on
               || mode_o == MODE_HALT_SUB_ONLY_MODE
               || mode_o == MODE_HALT_BOTH_CLOCKS_MODE;
      unique case (mode_o)
         MODE_FAST, MODE_SLOW:       sys_on = 1'b1;
         MODE_SLEEP:                 sys_on = 1'b0;
         MODE_HALT_SUB_ONLY_MODE:    sys_on = (act_sel_ff == SEL_SUB);
         MODE_HALT_BOTH_CLOCKS_MODE: sys_on = 1'b1;
         MODE_HALT_FAST_ONLY_MODE:   sys_on = (act_sel_ff != SEL_SUB);
         default:                    sys_on = 1'b0;
      endcase
      cur_tick  = sel_tick(act_sel_ff, div_tick, slow_raw);
      tgt_tick  = sel_tick(scc_ff.sysclk_select, div_tick, slow_raw);
      tgt_ready = (scc_ff.sysclk_select == SEL_SUB) || fosc_stb_ff;
   end

   // ----------------------------------------------------------------
   // Mode and source switch
   // ----------------------------------------------------------------
   always_comb begin
      nxt_mode    = mode_o;
      nxt_act_sel = act_sel_ff;
      nxt_sw_cnt  = sw_cnt_ff;
      switch_done = 1'b0;
      halt_evt    = 1'b0;
      if (cpu_on) begin
         // Count current source ticks, then hand over on a target tick
         if (scc_ff.sysclk_select != act_sel_ff) begin
            if (sw_cnt_ff < SWITCH_SYS_TICKS) begin
               if (cur_tick) begin
                  nxt_sw_cnt = sw_cnt_ff + 1'b1;
               end
            end else if (tgt_tick && tgt_ready) begin
               nxt_act_sel = scc_ff.sysclk_select;
               nxt_sw_cnt  = '0;
               switch_done = 1'b1;
            end
         end else begin
            nxt_sw_cnt = '0;
         end
         if (halt_i) begin
            halt_evt = 1'b1;
            unique case ({scc_ff.halt_fast_keep, scc_ff.halt_slow_keep})
               2'b00: nxt_mode = MODE_SLEEP;
               2'b01: nxt_mode = MODE_HALT_SUB_ONLY_MODE;
               2'b11: nxt_mode = MODE_HALT_BOTH_CLOCKS_MODE;
               2'b10: nxt_mode = MODE_HALT_FAST_ONLY_MODE;
            endcase
         end else begin
            nxt_mode = (nxt_act_sel == SEL_SUB) ? MODE_SLOW
                                                : MODE_FAST;
         end
      end else if (wake_i) begin
         nxt_mode = (act_sel_ff == SEL_SUB) ? MODE_SLOW : MODE_FAST;
      end
      nxt_busy = (scc_ff.sysclk_select != nxt_act_sel);
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_o        <= MODE_FAST;
         act_sel_ff    <= SEL_FAST_DIV1;
         sw_cnt_ff     <= '0;
         switch_busy_o <= 1'b0;
      end else begin
         mode_o        <= nxt_mode;
         act_sel_ff    <= nxt_act_sel;
         sw_cnt_ff     <= nxt_sw_cnt;
         switch_busy_o <= nxt_busy;
      end
   end

   // ----------------------------------------------------------------
   // Registers, settle timer and interrupts
   // ----------------------------------------------------------------
   always_comb begin
      wr_scc  = reg_req_i.wr && reg_req_i.addr == ADDR_SYS_CLOCK_CTRL;
      wr_fosc = reg_req_i.wr && reg_req_i.addr == ADDR_FAST_OSC_CTRL;
      wr_ien  = reg_req_i.wr && reg_req_i.addr == ADDR_INT_ENABLE;
      wr_iclr = reg_req_i.wr && reg_req_i.addr == ADDR_INT_CLEAR;

      nxt_scc = scc_ff;
      if (wr_scc) begin
         nxt_scc     = scm_sys_clock_ctrl_s'(reg_req_i.wdata);
         nxt_scc.rsv = '0;
      end

      nxt_fosc_en  = wr_fosc ? reg_req_i.wdata[0] : fosc_en_ff;
      nxt_fosc_stb = fosc_stb_ff;
      nxt_settle   = settle_ff;
      events       = '0;
      if ((wr_fosc && reg_req_i.wdata[0] && !fosc_en_ff) || !fast_run) begin
         nxt_fosc_stb = 1'b0;
         nxt_settle   = '0;
      end else if (!fosc_stb_ff) begin
         if (settle_ff == SETTLE_W'(SETTLE_CYC - 1)) begin
            nxt_fosc_stb       = 1'b1;
            events[INT_STABLE] = 1'b1;
         end else begin
            nxt_settle = settle_ff + 1'b1;
         end
      end
      events[INT_SWITCH] = switch_done;
      events[INT_HALT]   = halt_evt;

      nxt_int_en = wr_ien ? reg_req_i.wdata[INT_W-1:0] : int_en_ff;
      // New events win over a clear in the same cycle
      nxt_int_sts = int_sts_ff;
      if (wr_iclr) begin
         nxt_int_sts = int_sts_ff & ~reg_req_i.wdata[INT_W-1:0];
      end
      nxt_int_sts = nxt_int_sts | events;
      nxt_irq     = |(nxt_int_sts & nxt_int_en);

      nxt_rdata = '0;
      if (reg_req_i.rd) begin
         unique case (reg_req_i.addr)
            ADDR_SYS_CLOCK_CTRL: nxt_rdata = scc_ff;
            ADDR_FAST_OSC_CTRL:  nxt_rdata = {6'h00, fosc_stb_ff,
                                              fosc_en_ff};
            ADDR_INT_STATUS:     nxt_rdata = {5'h00, int_sts_ff};
            ADDR_INT_ENABLE:     nxt_rdata = {5'h00, int_en_ff};
            ADDR_MODE_STATUS:    nxt_rdata = {switch_busy_o, 1'b0, mode_o};
            default:             nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         scc_ff      <= scm_sys_clock_ctrl_s'(SCC_RST);
         fosc_en_ff  <= FOSC_EN_RST;
         fosc_stb_ff <= FOSC_STB_RST;
         settle_ff   <= '0;
         int_sts_ff  <= '0;
         int_en_ff   <= '0;
         irq_o       <= 1'b0;
         rdata_o     <= '0;
      end else begin
         scc_ff      <= nxt_scc;
         fosc_en_ff  <= nxt_fosc_en;
         fosc_stb_ff <= nxt_fosc_stb;
         settle_ff   <= nxt_settle;
         int_sts_ff  <= nxt_int_sts;
         int_en_ff   <= nxt_int_en;
         irq_o       <= nxt_irq;
         rdata_o     <= nxt_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Registered clock enables
   // ----------------------------------------------------------------
   always_comb begin
      nxt_clk_en.sys  = sys_on && cur_tick;
      nxt_clk_en.cpu  = cpu_on && cur_tick;
      // Gate with the run request so a halt stops the tick at once
      nxt_clk_en.fast = fast_raw && fast_run;
      nxt_clk_en.sub  = sub_on && slow_raw;
      nxt_clk_en.slow = slow_raw;
      nxt_fast_div    = fast_run ? div_tick : '0;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         clk_en_o      <= '0;
         fast_div_en_o <= '0;
      end else begin
         clk_en_o      <= nxt_clk_en;
         fast_div_en_o <= nxt_fast_div;
      end
   end

endmodule
`default_nettype wire

// *** test/scm_top_monitor.sv ***
// Port-level assertions for the clock mode control
`timescale 1ns/1ns
`default_nettype none
module scm_top_monitor
   import scm_pkg::*;
(
   input wire logic                ref_clk_i,
   input wire logic                rst_i,
   input wire scm_reg_req_s        reg_req_i,
   input wire logic                halt_i,
   input wire logic                wake_i,
   input wire logic [DATA_W-1:0]   rdata_o,
   input wire scm_clk_en_s         clk_en_o,
   input wire logic [DIV_TAPS-1:0] fast_div_en_o,
   input wire scm_mode_e           mode_o,
   input wire logic                switch_busy_o,
   input wire logic                irq_o
);
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   logic run;
   assign run = mode_o inside {MODE_FAST, MODE_SLOW};

   chk_mode_onehot: assert property ($onehot(mode_o))
      else $error("mode not one-hot");
   chk_halt_enters: assert property (halt_i && run |=> !run)
      else $error("halt not taken");
   chk_wake_exits: assert property (wake_i && !run |=> run)
      else $error("wake not taken");
   // Settled halt only: clock enables lag the mode by a cycle
   chk_halt_cpu_off: assert property (!run && $stable(mode_o)
      |-> !clk_en_o.cpu)
      else $error("cpu clock in halt");
   chk_sleep_all_off: assert property (mode_o == MODE_SLEEP && $stable(mode_o)
      |-> !(clk_en_o.sys || clk_en_o.fast || clk_en_o.sub))
      else $error("clock running in sleep");
   chk_sub_only_fast: assert property (mode_o == MODE_HALT_SUB_ONLY_MODE
      && $stable(mode_o) |-> !clk_en_o.fast)
      else $error("fast clock in sub-only halt");
   chk_fast_only_sub: assert property (mode_o == MODE_HALT_FAST_ONLY_MODE
      && $stable(mode_o) |-> !clk_en_o.sub)
      else $error("sub clock in fast-only halt");
   chk_both_fast_runs: assert property (mode_o == MODE_HALT_BOTH_CLOCKS_MODE
      && $stable(mode_o) |-> ##[0:2] clk_en_o.fast)
      else $error("fast clock stopped in both-clocks halt");
   chk_slow_always: assert property (clk_en_o.slow
      |=> ##[1:800] clk_en_o.slow)
      else $error("slow oscillator tick missing");
   chk_cpu_on_sys: assert property (clk_en_o.cpu |-> clk_en_o.sys)
      else $error("cpu tick without system tick");
   chk_rdata_idle: assert property (!$past(reg_req_i.rd)
      |-> rdata_o == 8'h00)
      else $error("read data outside read slot");
endmodule

bind scm_top scm_top_monitor u_mon (.ref_clk_i, .rst_i, .reg_req_i, .halt_i,
   .wake_i, .rdata_o, .clk_en_o, .fast_div_en_o, .mode_o, .switch_busy_o,
   .irq_o);
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the clock mode control
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import scm_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals and design
   // ---------------------------------------------------------------
   localparam int ST = 8;
   logic                ref_clk_i = 1'b0;
   logic                rst_i     = 1'b1;
   logic                halt_i    = 1'b0;
   logic                wake_i    = 1'b0;
   scm_reg_req_s        req       = '0;
   logic [7:0]          rdata_o;
   logic [7:0]          d;
   logic [7:0]          lf        = 8'h5c;
   scm_clk_en_s         clk_en_o;
   logic [DIV_TAPS-1:0] div_o;
   scm_mode_e           mode_o;
   logic                busy_o;
   logic                irq_o;
   int                  bad_count = 0;
   int                  samples_checked = 0;
   int                  cyc = 0;
   int                  n[6];
   scm_mode_e hm[4] = '{MODE_SLEEP, MODE_HALT_SUB_ONLY_MODE,
                        MODE_HALT_FAST_ONLY_MODE, MODE_HALT_BOTH_CLOCKS_MODE};

   scm_top #(.SETTLE_CYC(ST)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .reg_req_i(req), .halt_i(halt_i), .wake_i(wake_i), .rdata_o(rdata_o),
      .clk_en_o(clk_en_o), .fast_div_en_o(div_o), .mode_o(mode_o),
      .switch_busy_o(busy_o), .irq_o(irq_o));

   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // Hang guard, well above the roughly 25k cycles the run needs
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         results();
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] nx(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   // Tick counts: one tick of slack for window phase
   task automatic chk_cnt(input int e, input int g);
      samples_checked++;
      if (g < e - 1 || g > e + 1) begin
         bad_count++;
         $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      req <= '{a, v, 1'b1, 1'b0};
      @(posedge ref_clk_i);
      req.wr <= 1'b0;
   endtask

   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk_i);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk_i);
      req.rd <= 1'b0;
      #1 d = rdata_o;
      chk(e, d);
   endtask

   task automatic pulse(input logic hlt);
      @(posedge ref_clk_i);
      if (hlt) halt_i <= 1'b1; else wake_i <= 1'b1;
      @(posedge ref_clk_i);
      halt_i <= 1'b0;
      wake_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wbusy();
      repeat (2) @(posedge ref_clk_i);
      // Sub to fast needs four sub ticks, over 3100 cycles
      for (int i = 0; i < 4000 && busy_o !== 1'b0; i++) @(posedge ref_clk_i);
      #1 chk(8'h00, {7'b0, busy_o});
   endtask

   task automatic cnt(input int len, input int k);
      n = '{default: 0};
      repeat (len) begin
         @(posedge ref_clk_i);
         #1;
         n[0] += clk_en_o.cpu;
         n[1] += clk_en_o.sys;
         n[2] += clk_en_o.fast;
         n[3] += clk_en_o.sub;
         n[4] += div_o[k];
         n[5] += clk_en_o.slow;
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rc(ADDR_SYS_CLOCK_CTRL, SCC_RST);
      rc(ADDR_FAST_OSC_CTRL, 8'h01);
      chk(8'h01, {2'b00, mode_o});
      repeat (ST + 4) @(posedge ref_clk_i);
      rc(ADDR_FAST_OSC_CTRL, 8'h03);
      rc(ADDR_INT_STATUS, 8'h01);
      wr(ADDR_FAST_OSC_CTRL, 8'h00);
      wr(ADDR_FAST_OSC_CTRL, 8'hff);
      rc(ADDR_FAST_OSC_CTRL, 8'h01);
      repeat (ST + 4) @(posedge ref_clk_i);
      rc(ADDR_FAST_OSC_CTRL, 8'h03);
      $display("test reset_and_settle done");

      wr(ADDR_INT_ENABLE, 8'h01);
      repeat (2) @(posedge ref_clk_i);
      #1 chk(8'h01, {7'b0, irq_o});
      wr(ADDR_INT_CLEAR, 8'h07);
      repeat (2) @(posedge ref_clk_i);
      #1 chk(8'h00, {7'b0, irq_o});
      rc(ADDR_INT_STATUS, 8'h00);
      rc(ADDR_INT_CLEAR, 8'h00);
      rc(4'hf, 8'h00);
      for (int i = 0; i < 4; i++) begin
         lf = nx(lf);
         wr(ADDR_SYS_CLOCK_CTRL, {3'h0, lf[4:0]});
         rc(ADDR_SYS_CLOCK_CTRL, {6'h00, lf[1:0]});
         wr(ADDR_INT_STATUS, lf);
         rc(ADDR_INT_STATUS, 8'h00);
      end
      pulse(1'b0);
      chk(8'h01, {2'b00, mode_o});
      $display("test registers done");

      // 640 ref cycles hold 512 fast ticks
      for (int k = 0; k < 7; k++) begin
         wr(ADDR_SYS_CLOCK_CTRL, {k[2:0], 5'h00});
         wbusy();
         cnt(640, k);
         chk_cnt(512 >> k, n[0]);
         chk_cnt(512 >> k, n[4]);
      end
      $display("test divider done");

      wr(ADDR_INT_CLEAR, 8'h07);
      wr(ADDR_SYS_CLOCK_CTRL, 8'he0);
      repeat (2) @(posedge ref_clk_i);
      #1 chk(8'h01, {7'b0, busy_o});
      wbusy();
      chk(8'h02, {2'b00, mode_o});
      rc(ADDR_INT_STATUS, 8'h02);
      rc(ADDR_MODE_STATUS, 8'h02);
      cnt(1700, 0);
      chk_cnt(2, n[3]);
      chk_cnt(2, n[0]);
      chk_cnt(1360, n[2]);
      $display("test slow_switch done");

      for (int s = 1; s >= 0; s--) begin
         for (int h = 0; h < 4; h++) begin
            wr(ADDR_SYS_CLOCK_CTRL, {s ? 3'h7 : 3'h0, 3'h0, h[1:0]});
            wbusy();
            // Let a restarted fast oscillator settle before clearing
            repeat (ST + 2) @(posedge ref_clk_i);
            wr(ADDR_INT_CLEAR, 8'h07);
            pulse(1'b1);
            chk({2'b00, hm[h]}, {2'b00, mode_o});
            rc(ADDR_INT_STATUS, 8'h04);
            cnt(1700, 0);
            chk({7'b0, (h == 1 && s == 1) || h == 3 || (h == 2 && s == 0)},
                {7'b0, n[1] != 0});
            chk({7'b0, h[0]}, {7'b0, n[3] != 0});
            chk({7'b0, h[1]}, {7'b0, n[2] != 0});
            chk(8'h00, {7'b0, n[0] != 0});
            chk(8'h01, {7'b0, n[5] != 0});
            pulse(1'b1);
            chk({2'b00, hm[h]}, {2'b00, mode_o});
            pulse(1'b0);
            chk(s ? 8'h02 : 8'h01, {2'b00, mode_o});
         end
      end
      $display("test halt_modes done");
      results();
   end
endmodule
`default_nettype wire
